// File: dv/ca_bus_termination_control_tb.sv
// Self-checking bench joining the controller and device ends of the termination link.
`timescale 1ns/10ps
`include "ca_term_map.svh"
`define CHECK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); \
  end \
end
module ca_bus_termination_control_tb;
  logic        pclk, presetn, ce;         // Clock, reset and run enable.
  logic        psel, penable, pwrite;     // APB request.
  logic [7:0]  paddr;                     // APB address.
  logic [31:0] pwdata;                    // APB write data.
  logic [31:0] prdata_q;                  // APB read data.
  logic        pready_q, pslverr_q;       // APB answer.
  logic        ca_termination_strap;      // Die strap.
  logic        low_voltage_variant;       // Variant select.
  logic        ca_on, ck_on, cs_on;       // Termination enables seen at the device.
  logic [5:0]  rtt_select_q;              // One-hot resistance select.
  logic [2:0]  field_q;                   // Programmed value code.
  logic [31:0] rd;                        // Data of the last APB transfer.
  logic        err;                       // Error flag of the last APB transfer.
  int          comparisons, mismatches, cycles;
  ca_term_if link_if ();
  ca_term_ctrl u_ca_term_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q), .link(link_if));
  ca_term_device u_ca_term_device (.pclk(pclk), .presetn(presetn), .ce(ce), .link(link_if),
    .ca_termination_strap(ca_termination_strap), .low_voltage_variant(low_voltage_variant),
    .ca_lines_term_on_q(ca_on), .clock_pair_term_on_q(ck_on), .select_term_on_q(cs_on),
    .rtt_select_q(rtt_select_q), .ca_term_value_field_q(field_q));
  ca_term_checker u_ca_term_checker (.pclk(pclk), .presetn(presetn), .ck(link_if.ck),
    .cs(link_if.cs), .ca(link_if.ca), .ca_termination_strap(ca_termination_strap),
    .low_voltage_variant(low_voltage_variant), .ca_lines_term_on_q(ca_on),
    .clock_pair_term_on_q(ck_on), .select_term_on_q(cs_on), .rtt_select_q(rtt_select_q),
    .ca_term_value_field_q(field_q));
  // Free-running 250 MHz core clock.
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  // Cuts a hung run short; the whole sequence needs well under this many cycles.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  // One APB transfer; holds the request until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready_q !== 1'b1);
    rd = prdata_q;
    err = pslverr_q;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  // Issues one mode register write and polls until the frame has been sent.
  task automatic send_cmd(input logic [5:0] mr, input logic [7:0] d);
    apb(1'b1, `CT_OFF_CMD, {16'h0000, d, 2'b00, mr});
    do begin
      apb(1'b0, `CT_OFF_STATUS, 32'h0000_0000);
    end while (rd[`CT_ST_BUSY] !== 1'b0);
  endtask : send_cmd
  // Compares the three enables and the programmed code with expectations.
  task automatic check_outs(input logic a, input logic k, input logic s, input logic [2:0] c);
    `CHECK(ca_on, a)
    `CHECK(ck_on, k)
    `CHECK(cs_on, s)
    `CHECK(field_q, c)
  endtask : check_outs
  // Reset state, and an unmapped address answered with an error.
  task automatic t_reset_map();
    check_outs(1'b0, 1'b0, 1'b0, 3'h0);
    `CHECK(rtt_select_q, 6'h00)
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHECK(err, 1'b1)
  endtask : t_reset_map
  // Enabling a value before the disables are programmed is refused.
  task automatic t_order();
    send_cmd(`CT_MR_VALUE, 8'h20);
    `CHECK(rd[`CT_ST_REFUSED], 1'b1)
    check_outs(1'b0, 1'b0, 1'b0, 3'h0);
  endtask : t_order
  // Every code, with the other data bits set to prove the field position.
  task automatic t_codes();
    logic [2:0] c;
    logic       v;
    send_cmd(`CT_MR_DISABLE, 8'h00);
    `CHECK(rd[`CT_ST_DIS_DONE], 1'b1)
    for (int i = 1; i <= 8; i++) begin
      c = 3'(i);
      v = (c != 3'h0) && (c != 3'h7);
      send_cmd(`CT_MR_VALUE, {1'b1, c, 4'hF});
      check_outs(v, v, v, c);
      `CHECK(rtt_select_q, v ? (6'h01 << (c - 3'h1)) : 6'h00)
      `CHECK(rd[`CT_ST_RECAL], 1'b0)
    end
  endtask : t_codes
  // All disable combinations, then the off code with no disables set.
  task automatic t_disables();
    logic [2:0] dis;
    send_cmd(`CT_MR_VALUE, 8'h30);
    for (int d = 7; d >= 0; d--) begin
      dis = 3'(d);
      send_cmd(`CT_MR_DISABLE, {2'b00, dis, 3'b000});
      check_outs(!dis[2], !dis[0], !dis[1], 3'h3);
    end
    send_cmd(`CT_MR_VALUE, 8'h00);
    check_outs(1'b0, 1'b0, 1'b0, 3'h0);
  endtask : t_disables
  // Strap gating in the strapped variant, and the strap ignored in the other.
  task automatic t_strap();
    low_voltage_variant <= 1'b0;
    send_cmd(`CT_MR_VALUE, 8'h50);
    check_outs(1'b0, 1'b0, 1'b0, 3'h5);
    ca_termination_strap <= 1'b1;
    repeat (6) @(posedge pclk);
    check_outs(1'b1, 1'b1, 1'b1, 3'h5);
    `CHECK(rtt_select_q, 6'h10)
    low_voltage_variant <= 1'b1;
    ca_termination_strap <= 1'b0;
    repeat (6) @(posedge pclk);
    check_outs(1'b1, 1'b1, 1'b1, 3'h5);
  endtask : t_strap
  // A calibration point change owes a new calibration; values change freely after it.
  task automatic t_cal();
    apb(1'b1, `CT_OFF_CAL, 32'h0000_0001);
    apb(1'b0, `CT_OFF_STATUS, 32'h0000_0000);
    `CHECK(rd[`CT_ST_RECAL], 1'b1)
    apb(1'b1, `CT_OFF_CAL, 32'h0000_0003);
    apb(1'b0, `CT_OFF_STATUS, 32'h0000_0000);
    `CHECK(rd[`CT_ST_RECAL], 1'b0)
    send_cmd(`CT_MR_VALUE, 8'h60);
    check_outs(1'b1, 1'b1, 1'b1, 3'h6);
  endtask : t_cal
  // Training the other ranks first is flagged; the proper order is then accepted.
  task automatic t_train();
    apb(1'b1, `CT_OFF_TRAIN, 32'h0000_0002);
    apb(1'b0, `CT_OFF_STATUS, 32'h0000_0000);
    `CHECK(rd[`CT_ST_ORDER_ERR], 1'b1)
    apb(1'b1, `CT_OFF_TRAIN, 32'h0000_0001);
    apb(1'b1, `CT_OFF_TRAIN, 32'h0000_0003);
    apb(1'b0, `CT_OFF_TRAIN, 32'h0000_0000);
    `CHECK(rd[1:0], 2'h3)
  endtask : t_train
  // Main sequence: reset, then every scenario in turn.
  initial begin
    presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0000_0000; ca_termination_strap = 1'b0;
    low_voltage_variant = 1'b1; comparisons = 0; mismatches = 0; cycles = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_order();
    t_codes();
    t_disables();
    t_strap();
    t_cal();
    t_train();
    print_verdict();
  end
endmodule : ca_bus_termination_control_tb

// File: dv/ca_term_checker.sv
// Concurrent checks on the termination link and on the device outputs.
`timescale 1ns/10ps
module ca_term_checker (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       ck,
  input wire logic       cs,
  input wire logic [5:0] ca,
  input wire logic       ca_termination_strap,
  input wire logic       low_voltage_variant,
  input wire logic       ca_lines_term_on_q,
  input wire logic       clock_pair_term_on_q,
  input wire logic       select_term_on_q,
  input wire logic [5:0] rtt_select_q,
  input wire logic [2:0] ca_term_value_field_q
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] cs_len_q;    // Cycles the frame marker has stood high.
  logic [7:0] ck_half_q;   // Cycles since the link clock last moved.
  logic [7:0] since_cs_q;  // Cycles since the last frame began.
  logic       ck_seen_q;   // The link clock has moved once since reset.
  // Counters that measure the link timing; ck_half_q and since_cs_q saturate, cs_len_q can wrap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_len_q   <= 8'h00;
      ck_half_q  <= 8'h00;
      since_cs_q <= 8'hFF;
      ck_seen_q  <= 1'b0;
    end else begin
      cs_len_q   <= cs ? cs_len_q + 8'h01 : 8'h00;
      ck_half_q  <= $changed(ck) ? 8'h01 : ck_half_q + {7'h00, ck_half_q != 8'hFF};
      since_cs_q <= $rose(cs) ? 8'h01 : since_cs_q + {7'h00, since_cs_q != 8'hFF};
      ck_seen_q  <= ck_seen_q | $changed(ck);
    end
  end
  property p_reset_off;
    $rose(presetn) |-> !ca_lines_term_on_q && !clock_pair_term_on_q && !select_term_on_q
      && ca_term_value_field_q == 3'h0;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("termination on after reset");
  property p_rtt_decode;
    $stable(ca_term_value_field_q)[*2] ##0 ca_lines_term_on_q
      |-> rtt_select_q == (6'h01 << (ca_term_value_field_q - 3'h1));
  endproperty
  a_rtt_decode: assert property (p_rtt_decode) else $error("resistance select wrong");
  property p_code_off;
    $stable(ca_term_value_field_q)[*2] ##0 (ca_term_value_field_q inside {3'h0, 3'h7})
      |-> !ca_lines_term_on_q && !clock_pair_term_on_q && !select_term_on_q
      && rtt_select_q == 6'h00;
  endproperty
  a_code_off: assert property (p_code_off) else $error("termination on with off code");
  property p_strap_off;
    (!low_voltage_variant && !ca_termination_strap)[*5]
      |-> !ca_lines_term_on_q && !clock_pair_term_on_q && !select_term_on_q;
  endproperty
  a_strap_off: assert property (p_strap_off) else $error("termination on with low strap");
  property p_field_after_frame;
    $changed(ca_term_value_field_q) |-> since_cs_q inside {[8'h5A:8'h78]};
  endproperty
  a_field_after_frame: assert property (p_field_after_frame) else $error("field too soon");
  property p_cs_one_period;
    $fell(cs) |-> cs_len_q == 8'h28;
  endproperty
  a_cs_one_period: assert property (p_cs_one_period) else $error("marker length wrong");
  property p_change_on_fall;
    (!$stable(cs) || !$stable(ca)) |-> $fell(ck);
  endproperty
  a_change_on_fall: assert property (p_change_on_fall) else $error("lines moved early");
  property p_ck_half;
    $changed(ck) && ck_seen_q |-> ck_half_q == 8'h14;
  endproperty
  a_ck_half: assert property (p_ck_half) else $error("link clock half period wrong");
endmodule : ca_term_checker

// File: include/ca_term_if.sv
// Command link between controller and device: clock, select, six lines.
`timescale 1ns/10ps
interface ca_term_if;
  logic       ck;  // Link clock made by the controller.
  logic       cs;  // Frame start marker, high for the first beat.
  logic [5:0] ca;  // Command/address lines.
  // Controller end drives the link.
  modport ctrl_mp (output ck, output cs, output ca);
  // Device end only listens.
  modport dev_mp (input ck, input cs, input ca);
endinterface : ca_term_if

// File: include/ca_term_map.svh
// Offsets, field positions, codes and timing counts of the termination link.
`ifndef CA_TERM_MAP_SVH
`define CA_TERM_MAP_SVH
// Mode register addresses carried in the first beat of a write frame.
`define CT_MR_VALUE      6'h0B
`define CT_MR_DISABLE    6'h16
// Termination value field inside the value register.
`define CT_VAL_MSB       6
`define CT_VAL_LSB       4
`define CT_VAL_OFF       3'h0
`define CT_VAL_RSVD      3'h7
`define CT_VAL_FIRST     1
`define CT_RTT_NUM       6
// Per-signal disable bits inside the disable register.
`define CT_DIS_CK_BIT    3
`define CT_DIS_CS_BIT    4
`define CT_DIS_CA_BIT    5
// Link clock half period in pclk cycles: 80 ns at 4 ns per cycle.
`define CT_LINK_HALF_NS  80
`define CT_PCLK_NS       4
`define CT_LINK_HALF     5'((`CT_LINK_HALF_NS) / (`CT_PCLK_NS))
// Controller register offsets on APB.
`define CT_OFF_CMD       8'h00
`define CT_OFF_STATUS    8'h04
`define CT_OFF_CAL       8'h08
`define CT_OFF_TRAIN     8'h0C
// Command register fields.
`define CT_CMD_ADDR_MSB  5
`define CT_CMD_DATA_MSB  15
`define CT_CMD_DATA_LSB  8
// Status register bits.
`define CT_ST_BUSY       0
`define CT_ST_REFUSED    1
`define CT_ST_DIS_DONE   2
`define CT_ST_RECAL      3
`define CT_ST_ORDER_ERR  4
// Calibration and training register bits.
`define CT_CAL_POINT     0
`define CT_CAL_DONE      1
`define CT_TR_TERM       0
`define CT_TR_OTHER      1
`endif

// File: include/ca_term_pkg.sv
// Types shared by both ends of the termination link.
package ca_term_pkg;
  // Receiver progress through a three-beat write frame.
  typedef enum logic [1:0] {RX_IDLE, RX_DATA_LO, RX_DATA_HI} rx_state_e;
  // Sender progress through a three-beat write frame.
  typedef enum logic [1:0] {TX_IDLE, TX_ADDR, TX_DATA_LO, TX_DATA_HI} tx_state_e;
  // Per-signal disable flags.
  typedef struct packed {
    logic ca;
    logic ck;
    logic cs;
  } term_dis_s;
endpackage : ca_term_pkg

// File: src/ca_term_ctrl.sv
// Controller end: APB registers, write-order checks and link frame sender.
`timescale 1ns/10ps
`include "ca_term_map.svh"

module ca_term_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata_q,
  output logic             pready_q,
  output logic             pslverr_q,
  ca_term_if.ctrl_mp       link
);
  logic [4:0]             div_q;       // Link clock divider count.
  logic                   ck_q;        // Link clock level.
  wire logic              tick;        // Half period elapsed.
  wire logic              fall;        // Link clock about to fall.
  ca_term_pkg::tx_state_e tx_q;        // Frame sender state.
  logic                   cs_q;        // Driven select level.
  logic [5:0]             ca_q;        // Driven command/address lines.
  logic                   pend_q;      // Command waiting for a frame.
  logic [5:0]             addr_q;      // Queued register address.
  logic [7:0]             data_q;      // Queued data byte.
  logic                   refused_q;   // Last command was refused.
  logic                   dis_done_q;  // Disable register already written.
  logic                   cal_pt_q;    // Selected calibration point.
  logic                   recal_q;     // Calibration owed after point change.
  logic                   tr_term_q;   // Terminating rank trained.
  logic                   tr_other_q;  // Other ranks trained.
  logic                   order_err_q; // Training order broken.
  wire logic              busy;        // Command or frame in flight.
  wire logic              acc;         // Access phase completes this edge.
  wire logic              wr;          // Completed write.
  wire logic              sel_cmd;     // Address decodes.
  wire logic              sel_st;
  wire logic              sel_cal;
  wire logic              sel_tr;
  wire logic              mapped;      // Any register hit.
  wire logic [5:0]        w_addr;      // Command fields from write data.
  wire logic [7:0]        w_data;
  wire logic              w_enables;   // Command enables termination.
  wire logic              cmd_wr;      // Command write seen.
  wire logic              cmd_refuse;  // Command write refused.
  wire logic              cmd_take;    // Command write accepted.
  wire logic [31:0]       rd_mux;      // Read data selection.

  // Link clock derived from pclk by a divider, running free.
  assign tick = (div_q == `CT_LINK_HALF - 5'h01);
  assign fall = tick & ck_q;

  // APB decode; the answer comes one cycle into the access phase.
  assign acc     = psel & penable & pready_q;
  assign wr      = acc & pwrite;
  assign sel_cmd = (paddr == `CT_OFF_CMD);
  assign sel_st  = (paddr == `CT_OFF_STATUS);
  assign sel_cal = (paddr == `CT_OFF_CAL);
  assign sel_tr  = (paddr == `CT_OFF_TRAIN);
  assign mapped  = sel_cmd | sel_st | sel_cal | sel_tr;
  assign busy    = pend_q | (tx_q != ca_term_pkg::TX_IDLE);

  // A value-register write that enables termination is refused until the disables are written.
  assign w_addr     = pwdata[`CT_CMD_ADDR_MSB:0];
  assign w_data     = pwdata[`CT_CMD_DATA_MSB:`CT_CMD_DATA_LSB];
  assign w_enables  = (w_data[`CT_VAL_MSB:`CT_VAL_LSB] != `CT_VAL_OFF);
  assign cmd_wr     = wr & sel_cmd;
  assign cmd_refuse = cmd_wr & (busy |
    ((w_addr == `CT_MR_VALUE) & w_enables & ~dis_done_q));
  assign cmd_take   = cmd_wr & ~cmd_refuse;

  // Read data for each register; unmapped reads return zero.
  assign rd_mux = sel_st ? {27'h0, order_err_q, recal_q, dis_done_q, refused_q, busy}
                : sel_cmd ? {16'h0, data_q, 2'h0, addr_q}
                : sel_cal ? {31'h0, cal_pt_q}
                : sel_tr ? {30'h0, tr_other_q, tr_term_q}
                : 32'h0;

  // APB answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else if (ce) begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q  <= rd_mux;
    end
  end

  // Command queue, order checks and calibration bookkeeping.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q      <= 6'h00;
      data_q      <= 8'h00;
      refused_q   <= 1'b0;
      dis_done_q  <= 1'b0;
      cal_pt_q    <= 1'b0;
      recal_q     <= 1'b0;
      tr_term_q   <= 1'b0;
      tr_other_q  <= 1'b0;
      order_err_q <= 1'b0;
    end else if (ce) begin
      if (cmd_take) begin
        addr_q    <= w_addr;
        data_q    <= w_data;
        refused_q <= 1'b0;
        // Value writes never touch the calibration flag.
        if (w_addr == `CT_MR_DISABLE) begin
          dis_done_q <= 1'b1;
        end
      end else if (cmd_refuse) begin
        refused_q <= 1'b1;
      end
      // A point change owes a calibration; the set wins over the clear.
      if (wr && sel_cal) begin
        cal_pt_q <= pwdata[`CT_CAL_POINT];
        if (pwdata[`CT_CAL_POINT] != cal_pt_q) begin
          recal_q <= 1'b1;
        end else if (pwdata[`CT_CAL_DONE]) begin
          recal_q <= 1'b0;
        end
      end
      // The terminating rank must be trained before the others.
      if (wr && sel_tr) begin
        tr_term_q <= tr_term_q | pwdata[`CT_TR_TERM];
        if (pwdata[`CT_TR_OTHER] && !(tr_term_q || pwdata[`CT_TR_TERM])) begin
          order_err_q <= 1'b1;
        end else begin
          tr_other_q <= tr_other_q | pwdata[`CT_TR_OTHER];
        end
      end
    end
  end

  // Divider and frame sender; lines change at link falling edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 5'h00;
      ck_q   <= 1'b0;
      tx_q   <= ca_term_pkg::TX_IDLE;
      cs_q   <= 1'b0;
      ca_q   <= 6'h00;
      pend_q <= 1'b0;
    end else if (ce) begin
      div_q <= tick ? 5'h00 : div_q + 5'h01;
      if (tick) begin
        ck_q <= ~ck_q;
      end
      if (cmd_take) begin
        pend_q <= 1'b1;
      end
      if (fall) begin
        case (tx_q)
          ca_term_pkg::TX_IDLE: begin
            // Open a frame with the address beat.
            if (pend_q) begin
              cs_q   <= 1'b1;
              ca_q   <= addr_q;
              tx_q   <= ca_term_pkg::TX_ADDR;
              pend_q <= 1'b0;
            end
          end
          ca_term_pkg::TX_ADDR: begin
            cs_q <= 1'b0;
            ca_q <= data_q[5:0];
            tx_q <= ca_term_pkg::TX_DATA_LO;
          end
          ca_term_pkg::TX_DATA_LO: begin
            ca_q <= {4'h0, data_q[7:6]};
            tx_q <= ca_term_pkg::TX_DATA_HI;
          end
          default: begin
            // Device has committed at the previous rising edge.
            ca_q <= 6'h00;
            tx_q <= ca_term_pkg::TX_IDLE;
          end
        endcase
      end
    end
  end

  assign link.ck = ck_q;
  assign link.cs = cs_q;
  assign link.ca = ca_q;
endmodule : ca_term_ctrl

// File: src/ca_term_device.sv
// Device end: receives mode register writes and drives termination enables.
`timescale 1ns/10ps
`include "ca_term_map.svh"

// Operation
// - Termination off after reset until programmed.
// - Value field is bits 6 to 4.
// - Codes 1..6 select 240,120,80,60,48,40 ohm.
// - Termination covers clock pair, select, six lines.
// - Termination stays on through power-down states.
// - Low strap keeps termination off, except in the low-voltage variant.
// - High strap plus valid field terminates.
// - Low-voltage variant ignores strap entirely.
// - Disable bits 5,3,4 switch lines off.
// - Disabled field turns everything off.
// - Controller programs disables before enabling value.
// - Controller trains terminating rank first.
// - Value change honoured without recalibration.
// - Calibration point change needs new calibration.
module ca_term_device (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  ca_term_if.dev_mp         link,
  input  wire logic         ca_termination_strap,
  input  wire logic         low_voltage_variant,
  output logic              ca_lines_term_on_q,
  output logic              clock_pair_term_on_q,
  output logic              select_term_on_q,
  output logic [5:0]        rtt_select_q,
  output logic [2:0]        ca_term_value_field_q
);
  // Index of each synchronised input inside the group.
  localparam int SYNC_W = 10;
  localparam int I_LV   = 9;
  localparam int I_STR  = 8;
  localparam int I_CK   = 7;
  localparam int I_CS   = 6;

  logic [SYNC_W-1:0]      sync_raw;     // Pins and link as they arrive.
  logic [SYNC_W-1:0]      sync_q;       // Same group after two flops.
  wire logic              s_lv;         // Low-voltage variant level.
  wire logic              s_strap;      // Termination strap level.
  wire logic              s_ck;         // Link clock level.
  wire logic              s_cs;         // Frame start level.
  wire logic [5:0]        s_ca;         // Command/address lines.

  logic                   ck_prev_q;    // Link clock one pclk ago.
  wire logic              ck_rise;      // Rising edge of the link clock.

  ca_term_pkg::rx_state_e rx_q;         // Frame receiver state.
  ca_term_pkg::rx_state_e rx_d;         // Its next value.
  logic [5:0]             addr_q;       // Register address of this frame.
  logic [5:0]             data_lo_q;    // Low six data bits of this frame.
  wire logic [7:0]        frame_data;   // Full data byte at the last beat.
  wire logic              commit;       // Last beat of a frame taken.
  wire logic              hit_value;    // Frame addresses the value register.
  wire logic              hit_disable;  // Frame addresses the disable register.

  logic [2:0]             val_q;        // Programmed termination value code.
  wire logic [2:0]        val_d;        // Its next value.
  ca_term_pkg::term_dis_s dis_q;        // Programmed per-signal disables.
  ca_term_pkg::term_dis_s dis_d;        // Their next value.

  wire logic              val_ok;       // Code selects a real resistance.
  wire logic              strap_ok;     // Strap permits termination.
  wire logic              term_en;      // Termination enabled as a whole.
  wire logic [5:0]        rtt_hot;      // One-hot resistance select.

  // Everything from the pins passes two flops before any logic reads it.
  assign sync_raw = {low_voltage_variant, ca_termination_strap, link.ck, link.cs, link.ca};

  ca_term_sync #(
    .W (SYNC_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .async_in (sync_raw),
    .sync_q   (sync_q)
  );

  assign s_lv    = sync_q[I_LV];
  assign s_strap = sync_q[I_STR];
  assign s_ck    = sync_q[I_CK];
  assign s_cs    = sync_q[I_CS];
  assign s_ca    = sync_q[5:0];

  // The link clock is only sampled; its rising edge marks each beat.
  assign ck_rise = s_ck & ~ck_prev_q;

  // Frame receiver: address beat with select high, then two data beats.
  always_comb begin
    rx_d = rx_q;
    // Hold until a beat.
    case (rx_q)
      ca_term_pkg::RX_IDLE: begin
        // A beat with select high opens a frame.
        if (ck_rise && s_cs) begin
          rx_d = ca_term_pkg::RX_DATA_LO;
        end
      end
      ca_term_pkg::RX_DATA_LO: begin
        // The next beat carries the low data bits.
        if (ck_rise) begin
          rx_d = ca_term_pkg::RX_DATA_HI;
        end
      end
      ca_term_pkg::RX_DATA_HI: begin
        // The third beat ends the frame.
        if (ck_rise) begin
          rx_d = ca_term_pkg::RX_IDLE;
        end
      end
      default: begin
        rx_d = ca_term_pkg::RX_IDLE;
      end
    endcase
  end

  // The write is complete only at its third beat.
  assign commit      = ck_rise && (rx_q == ca_term_pkg::RX_DATA_HI);
  assign frame_data  = {s_ca[1:0], data_lo_q};
  assign hit_value   = commit && (addr_q == `CT_MR_VALUE);
  assign hit_disable = commit && (addr_q == `CT_MR_DISABLE);

  // New value applies whenever written; no calibration state is consulted.
  assign val_d = hit_value ? frame_data[`CT_VAL_MSB:`CT_VAL_LSB] : val_q;

  // Disable bits are taken only from a completed disable-register write.
  always_comb begin
    dis_d = dis_q;
    if (hit_disable) begin
      // Other bits ignored.
      dis_d.ca = frame_data[`CT_DIS_CA_BIT];
      dis_d.ck = frame_data[`CT_DIS_CK_BIT];
      dis_d.cs = frame_data[`CT_DIS_CS_BIT];
    end
  end

  // Receiver state and frame capture registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Link clock idles low: no false beat.
      ck_prev_q <= 1'b0;
      rx_q      <= ca_term_pkg::RX_IDLE;
      addr_q    <= 6'h00;
      data_lo_q <= 6'h00;
    end else if (ce) begin
      ck_prev_q <= s_ck;
      rx_q      <= rx_d;
      // Address is latched on the opening beat, low data on the second.
      if (ck_rise && (rx_q == ca_term_pkg::RX_IDLE) && s_cs) begin
        addr_q <= s_ca;
      end
      if (ck_rise && (rx_q == ca_term_pkg::RX_DATA_LO)) begin
        data_lo_q <= s_ca;
      end
    end
  end

  // Programmed settings; reset leaves the value code disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      val_q <= `CT_VAL_OFF;
      dis_q <= '0;
    end else if (ce) begin
      // Loaded only while ce is high.
      val_q <= val_d;
      dis_q <= dis_d;
    end
  end

  // Codes 000 and 111 give no termination.
  assign val_ok = (val_q != `CT_VAL_OFF) && (val_q != `CT_VAL_RSVD);

  // Low-voltage parts ignore the strap; others need it high.
  assign strap_ok = s_lv | s_strap;
  assign term_en  = val_ok & strap_ok;

  // One select line per resistance code, 240 ohm first.
  generate
    for (genvar i = 0; i < `CT_RTT_NUM; i++) begin : g_rtt
      assign rtt_hot[i] = term_en && (val_q == 3'(i + `CT_VAL_FIRST));
    end
  endgenerate

  // Outputs depend on no power state, so they hold through power-down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Everything off in reset.
      ca_lines_term_on_q    <= 1'b0;
      clock_pair_term_on_q  <= 1'b0;
      select_term_on_q      <= 1'b0;
      rtt_select_q          <= 6'h00;
      ca_term_value_field_q <= `CT_VAL_OFF;
    end else if (ce) begin
      // Gated per line.
      ca_lines_term_on_q    <= term_en & ~dis_q.ca;
      clock_pair_term_on_q  <= term_en & ~dis_q.ck;
      select_term_on_q      <= term_en & ~dis_q.cs;
      rtt_select_q          <= rtt_hot;
      ca_term_value_field_q <= val_q;
    end
  end
endmodule : ca_term_device

// File: src/ca_term_sync.sv
// Two-flop synchroniser for a group of levels from outside the pclk domain.
`timescale 1ns/10ps
module ca_term_sync #(
  parameter int W = 10
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_q
);
  logic [W-1:0] meta_q;  // First stage, read only by the second stage.

  // Both stages hold while the clock enable is low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
endmodule : ca_term_sync
